// File: inc/bbms_pkg.sv
// Package for the backup supply mode selector: mode codes, carriers and constants.
// Assumes one 25 MHz clock and comparator levels arriving from the analogue domain.
package bbms_pkg;

  // ----------------------------------------------------------------------
  // Switchover policy and configuration
  // ----------------------------------------------------------------------
  typedef enum logic {
    BBMS_SW_STANDARD,
    BBMS_SW_LEGACY
  } bbms_switch_t;

  typedef struct packed {
    logic serial_bus_inhibit_backup;
    logic battery_switch_select;
  } bbms_cfg_t;

  // Supply comparator results, both active high.
  typedef struct packed {
    logic below_trip;
    logic below_backup;
  } bbms_cmp_t;

  // Serial pin levels sampled from the bus.
  typedef struct packed {
    logic scl;
    logic sda;
  } bbms_bus_t;

  localparam bbms_cfg_t BBMS_CFG_RESET = 2'h0;
  localparam logic BBMS_SYNC_RESET = 1'h0;
  localparam int BBMS_SYNC_STAGES = 2;
  // Idle level of both bus lines, held there by the pull-ups.
  localparam bbms_bus_t BBMS_BUS_IDLE = 2'h3;
  // An open-drain enable at this level leaves the pin to its pull-up.
  localparam logic BBMS_OE_N_RELEASE = 1'h1;
  localparam logic BBMS_SERIAL_EN_RESET = 1'h1;

endpackage : bbms_pkg

// File: logic/bbms_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs are quasi-static compared with the clock.
`timescale 1ns/10ps
module bbms_sync
  import bbms_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_width_check
    $error("bbms_sync: WIDTH must be at least one");
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= {WIDTH{BBMS_SYNC_RESET}};
      sync_o <= {WIDTH{BBMS_SYNC_RESET}};
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule : bbms_sync

// File: logic/bbms_select.sv
// Backup supply mode selector: picks the switchover policy and gates the serial slave.
// Assumes comparator levels and bus pins are asynchronous; configuration comes from
// same-clock register logic elsewhere in the device.
`timescale 1ns/10ps
// What this block does
// R1 - Both config bits clear: standard switchover, serial slave stays alive in backup.
// R2 - Inhibit clear, select set: legacy switchover, serial slave alive in backup.
// R3 - Inhibit set, select clear: standard switchover, serial disabled during backup.
// R4 - Both bits set: legacy switchover, serial disabled during backup.
// R5 - Standard: enter backup when main supply is below lower of threshold and battery.
// R6 - Legacy: enter backup when main supply is below battery, threshold ignored.
// R7 - Interrupt and frequency output pin keeps working in backup in every mode.
// R8 - After power-up the switchover is standard until software chooses otherwise.
// R9 - Disabled serial interface ignores start conditions and never pulls data low.
module bbms_select
  import bbms_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration from device registers (same clock)
  input wire bbms_cfg_t cfg_i,
  input wire logic cfg_write_i,
  // Supply comparators (asynchronous)
  input wire bbms_cmp_t cmp_i,
  // Serial bus pins (asynchronous)
  input wire bbms_bus_t bus_i,
  // Serial slave's wish to pull data low (same clock)
  input wire logic slave_sda_low_i,
  // Interrupt or frequency source wish to pull its pin low (same clock)
  input wire logic irq_freq_low_i,
  // Status
  output logic backup_active_o,
  output bbms_switch_t switch_mode_o,
  output logic serial_enable_o,
  output logic start_seen_o,
  // Open-drain pins, enable low while driving
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic irq_freq_output_o,
  output logic irq_freq_output_oe_n_o
);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  localparam int SYNC_W = $bits(bbms_cmp_t) + $bits(bbms_bus_t);

  logic [SYNC_W-1:0] sync_vec;
  bbms_cmp_t cmp_s;
  bbms_bus_t bus_s;

  bbms_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({cmp_i, ~bus_i}),
    .sync_o(sync_vec)
  );

  // The bus lines pass the synchroniser inverted: its reset level of zero then
  // reads as idle high, so no false edge follows reset.
  assign cmp_s = sync_vec[SYNC_W-1 -: $bits(bbms_cmp_t)];
  assign bus_s = ~sync_vec[$bits(bbms_bus_t)-1:0];

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  bbms_cfg_t cfg;
  bbms_bus_t bus_d;

  function automatic bbms_switch_t decode_switch(input bbms_cfg_t c);
    decode_switch = c.battery_switch_select ? BBMS_SW_LEGACY : BBMS_SW_STANDARD;
  endfunction : decode_switch

  // The configuration is latched on write so that a glitch on the register
  // bus cannot flip the policy mid-switchover.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg <= BBMS_CFG_RESET; // R8
    end else if (cfg_write_i) begin
      cfg <= cfg_i;
    end
  end

  wire bbms_switch_t sw_now = decode_switch(cfg); // R1 R2 R3 R4
  // Below the lower of two levels means below both of them.
  wire std_enter = cmp_s.below_trip & cmp_s.below_backup; // R5
  wire leg_enter = cmp_s.below_backup; // R6
  wire next_backup = (sw_now == BBMS_SW_LEGACY) ? leg_enter : std_enter;
  // Inhibit only bites in backup; on main power the slave always runs.
  wire inhibit = cfg.serial_bus_inhibit_backup & next_backup; // R3 R4
  wire next_serial_en = ~inhibit; // R1 R2
  wire start_cond = bus_d.sda & ~bus_s.sda & bus_s.scl & bus_d.scl;
  wire next_start = start_cond & next_serial_en; // R9
  wire next_sda_drive = slave_sda_low_i & next_serial_en; // R9

  // ----------------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------------
  // Backup state and serial enable load from one synchronised sample, so
  // neither can be seen to change a cycle ahead of the other.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      backup_active_o <= 1'h0;
      switch_mode_o <= BBMS_SW_STANDARD;
      serial_enable_o <= BBMS_SERIAL_EN_RESET;
    end else begin
      backup_active_o <= next_backup; // R5 R6
      switch_mode_o <= sw_now;
      serial_enable_o <= next_serial_en;
    end
  end

  // ----------------------------------------------------------------------
  // Start detection
  // ----------------------------------------------------------------------
  // The delayed copy resets to the idle level of the lines, so the first
  // sample after reset cannot look like a falling data line.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_d <= BBMS_BUS_IDLE;
      start_seen_o <= 1'h0;
    end else begin
      bus_d <= bus_s;
      start_seen_o <= next_start;
    end
  end

  // ----------------------------------------------------------------------
  // Data line pull
  // ----------------------------------------------------------------------
  // The pin only ever pulls low: the data output stays at zero and the
  // enable alone decides whether the line is driven.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o <= 1'h0;
      sda_oe_n_o <= BBMS_OE_N_RELEASE;
    end else begin
      sda_o <= 1'h0;
      sda_oe_n_o <= ~next_sda_drive; // R9
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt and frequency pin
  // ----------------------------------------------------------------------
  // No backup term gates this pin: it keeps working in every mode, at the
  // cost of the battery current that its pull-up draws.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_freq_output_o <= 1'h0;
      irq_freq_output_oe_n_o <= BBMS_OE_N_RELEASE;
    end else begin
      irq_freq_output_o <= 1'h0;
      irq_freq_output_oe_n_o <= ~irq_freq_low_i; // R7
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  std_entry_a: assert property ( // R5
    (!cfg.battery_switch_select && cmp_s.below_trip && cmp_s.below_backup)
      |=> backup_active_o)
    else $error("standard switchover missed backup entry");
  std_hold_a: assert property ( // R5
    (!cfg.battery_switch_select && !cmp_s.below_trip) |=> !backup_active_o)
    else $error("standard switchover entered backup above threshold");
  leg_entry_a: assert property ( // R6
    (cfg.battery_switch_select && $stable(cfg)) |=> (backup_active_o == $past(cmp_s.below_backup)))
    else $error("legacy switchover does not follow battery comparator");
  inhibit_a: assert property ( // R3
    (backup_active_o && cfg.serial_bus_inhibit_backup && $stable(cfg)) |-> !serial_enable_o)
    else $error("serial interface alive in inhibited backup");
  keep_alive_a: assert property ( // R1
    (!cfg.serial_bus_inhibit_backup && $stable(cfg)) |=> serial_enable_o)
    else $error("serial interface disabled without inhibit");
  no_sda_a: assert property ( // R9
    !serial_enable_o |-> sda_oe_n_o)
    else $error("data line driven while serial disabled");
  no_start_a: assert property ( // R9
    !serial_enable_o |-> !start_seen_o)
    else $error("start condition taken while serial disabled");
  irq_pin_a: assert property ( // R7
    irq_freq_low_i |=> !irq_freq_output_oe_n_o)
    else $error("interrupt pin not driven in backup");
  mode_map_a: assert property ( // R2
    cfg_write_i |-> ##2 (switch_mode_o ==
      ($past(cfg_i.battery_switch_select, 2) ? BBMS_SW_LEGACY : BBMS_SW_STANDARD)))
    else $error("switch policy does not match select bit");
  irq_release_a: assert property ( // R7
    !irq_freq_low_i |=> irq_freq_output_oe_n_o)
    else $error("interrupt pin driven without a request");
  // Without inhibit the slave must still drive data and see starts.
  alive_sda_a: assert property ( // R2
    (!cfg.serial_bus_inhibit_backup && slave_sda_low_i) |=> !sda_oe_n_o)
    else $error("data line not driven while serial allowed");
  alive_start_a: assert property ( // R1
    (!cfg.serial_bus_inhibit_backup && start_cond) |=> start_seen_o)
    else $error("start condition lost while serial allowed");
  std_battery_a: assert property ( // R5
    (!cfg.battery_switch_select && !cmp_s.below_backup) |=> !backup_active_o)
    else $error("standard switchover entered backup above battery");
  leg_no_trip_a: assert property ( // R6
    (cfg.battery_switch_select && !cmp_s.below_trip && cmp_s.below_backup)
      |=> backup_active_o)
    else $error("legacy switchover waited for the threshold");
  // A reset must leave the policy standard until the next write lands.
  rst_standard_a: assert property ( // R8
    $rose(rst_n_i) |=> (switch_mode_o == BBMS_SW_STANDARD))
    else $error("switch policy not standard after reset");

  cov_std_backup_c: cover property (backup_active_o && switch_mode_o == BBMS_SW_STANDARD);
  cov_leg_backup_c: cover property (backup_active_o && switch_mode_o == BBMS_SW_LEGACY);
  cov_inhibit_c: cover property (backup_active_o && !serial_enable_o);
  cov_alive_c: cover property (backup_active_o && serial_enable_o && start_seen_o);
  cov_start_off_c: cover property (!serial_enable_o && start_cond);

endmodule : bbms_select

// File: verification/bbms_i2c_master.sv
// Behavioural two-wire bus master that makes start conditions on request.
// Assumes pull-ups on both lines; the device can only pull data low.
`timescale 1ns/10ps
module bbms_i2c_master
  import bbms_pkg::*;
(
  // Clock and request
  input wire logic clk_i,
  input wire logic start_i,
  // Device data pull, low while driving
  input wire logic sda_oe_n_i,
  // Bus levels seen by every party
  output bbms_bus_t bus_o
);
  logic scl = 1'h1;
  logic sda_drv = 1'h1;
  // The pull-up wins unless some party drives data low.
  assign bus_o = '{scl: scl, sda: sda_drv & sda_oe_n_i};
  always @(posedge clk_i) begin
    if (start_i) begin
      #1 sda_drv = 1'h0;
      repeat (6) @(posedge clk_i);
      #1 scl = 1'h0;
      repeat (2) @(posedge clk_i);
      #1 sda_drv = 1'h1;
      scl = 1'h1;
    end
  end
endmodule : bbms_i2c_master

// File: verification/testbench.sv
// Self-checking bench for the backup supply mode selector.
// Assumes the bus master model and the selector design are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module testbench
  import bbms_pkg::*;
;
  logic clk_i, rst_n_i, cfg_write_i, slave_sda_low_i, irq_freq_low_i, start;
  bbms_cfg_t cfg_i;
  bbms_cmp_t cmp_i;
  bbms_bus_t bus_i;
  logic backup_active_o, serial_enable_o, start_seen_o, sda_oe_n_o, irq_oe_n, sda_lvl, irq_lvl;
  bbms_switch_t switch_mode_o;
  logic [31:0] seed = 32'h8;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  bbms_select dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i),
    .cfg_write_i(cfg_write_i), .cmp_i(cmp_i), .bus_i(bus_i),
    .slave_sda_low_i(slave_sda_low_i), .irq_freq_low_i(irq_freq_low_i),
    .backup_active_o(backup_active_o), .switch_mode_o(switch_mode_o),
    .serial_enable_o(serial_enable_o), .start_seen_o(start_seen_o), .sda_o(sda_lvl),
    .sda_oe_n_o(sda_oe_n_o), .irq_freq_output_o(irq_lvl), .irq_freq_output_oe_n_o(irq_oe_n));
  bbms_i2c_master master_u (.clk_i(clk_i), .start_i(start), .sda_oe_n_i(sda_oe_n_o),
    .bus_o(bus_i));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[1:0];
  endfunction : rnd

  // Legacy trips on the battery alone; standard needs both comparators.
  function automatic logic exp_bk(logic [1:0] c, logic [1:0] m);
    return c[0] ? m[0] : (m[1] & m[0]);
  endfunction : exp_bk

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic run(input logic [1:0] c, input logic [1:0] m);
    logic [1:0] r;
    logic bk;
    logic [3:0] n;
    r = rnd();
    bk = exp_bk(c, m);
    cfg_i = c;
    cfg_write_i = 1'h1;
    cmp_i = m;
    slave_sda_low_i = r[0];
    irq_freq_low_i = r[1];
    @(posedge clk_i);
    #1 cfg_write_i = 1'h0;
    repeat (5) @(posedge clk_i);
    #1;
    `CHK("backup", bk, backup_active_o)
    `CHK("mode", bbms_switch_t'(c[0]), switch_mode_o)
    `CHK("enable", !(c[1] & bk), serial_enable_o)
    `CHK("sda_oe_n", !(r[0] & !(c[1] & bk)), sda_oe_n_o)
    `CHK("irq_oe_n", !r[1], irq_oe_n)
    `CHK("sda_o", 1'h0, sda_lvl)
    `CHK("irq_o", 1'h0, irq_lvl)
    // Release data first so the master's fall is a real start.
    slave_sda_low_i = 1'h0;
    repeat (4) @(posedge clk_i);
    #1 start = 1'h1;
    @(posedge clk_i);
    #1 start = 1'h0;
    n = 4'h0;
    repeat (12) begin
      @(posedge clk_i);
      #1 n += 4'(start_seen_o);
    end
    `CHK("starts", 4'(!(c[1] & bk)), n)
    $display("test cfg %0h cmp %0h done", c, m);
  endtask : run

  // ----------------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'h0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    {rst_n_i, cfg_write_i, slave_sda_low_i, irq_freq_low_i, start} = 5'h0;
    cfg_i = 2'h3;
    cmp_i = 2'h0;
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'h1;
    @(posedge clk_i);
    #1;
    `CHK("mode_rst", BBMS_SW_STANDARD, switch_mode_o)
    $display("test reset done");
    // First four runs hit the one-comparator corner, then random levels.
    for (int i = 0; i < 20; i++) begin
      run(2'(i), i < 4 ? 2'h1 : rnd());
    end
    // A reset in mid-run must drop the legacy choice of the last run.
    `CHK("mode_pre", BBMS_SW_LEGACY, switch_mode_o)
    rst_n_i = 1'h0;
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'h1;
    @(posedge clk_i);
    #1;
    `CHK("mode_rst2", BBMS_SW_STANDARD, switch_mode_o)
    `CHK("enable_rst2", 1'h1, serial_enable_o)
    `CHK("backup_rst2", 1'h0, backup_active_o)
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("mode_hold", BBMS_SW_STANDARD, switch_mode_o)
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : testbench
